// >>> rtl/slcr_bank.sv
// slot source selection and emitter drive register bank with apb slave
`timescale 1ns/1ps
`default_nettype none
module slcr_bank
	import slcr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SLCR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slot_a_active,
	input wire logic slot_b_active,
	output logic emitter_driver_one_en,
	output logic emitter_driver_two_en,
	output logic emitter_driver_three_en,
	output logic detector_pulse_connect,
	output logic [3:0] detector_input_route,
	output logic emitter3_strength_scale,
	output logic emitter3_low_power,
	output logic [2:0] emitter3_edge_rate,
	output logic [3:0] emitter3_coarse_current,
	output logic [4:0] emitter3_fine_trim,
	output logic emitter1_strength_scale,
	output logic emitter1_low_power,
	output logic [2:0] emitter1_edge_rate,
	output logic [3:0] emitter1_coarse_current,
	output logic [4:0] emitter1_fine_trim
);
	// ==========================================================
	// bus decode
	logic setup_phase;
	logic access_phase;
	logic [SLCR_NUM_REGS-1:0] hit;
	logic hit_any;
	logic [15:0] regs_reg [SLCR_NUM_REGS];
	logic [15:0] rd_word;
	logic [31:0] prdata_reg;

	function automatic logic slcr_reg_hit(input logic [SLCR_ADDR_W-1:0] addr,
		input logic [7:0] idx);
		slcr_reg_hit = (addr == slcr_byte_addr(idx));
	endfunction

	function automatic logic [15:0] slcr_merge(input logic [15:0] old,
		input logic [31:0] wdata, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0])
			res[7:0] = wdata[7:0];
		if (strb[1])
			res[15:8] = wdata[15:8];
		slcr_merge = res;
	endfunction

	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign hit_any = |hit;
	// zero wait states: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = access_phase & ~hit_any;
	assign prdata = prdata_reg;

	// ==========================================================
	// register file
	genvar g;
	generate
		for (g = 0; g < SLCR_NUM_REGS; g++)
		begin : gen_reg
			assign hit[g] = slcr_reg_hit(paddr, SLCR_IDX_LIST[g]);
			// store on write
			// reserved bits are stored too, so software sees what it wrote
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					regs_reg[g] <= SLCR_RST_LIST[g];
				else if (access_phase && pwrite && hit[g])
					regs_reg[g] <= slcr_merge(regs_reg[g], pwdata, pstrb);
			end
		end
	endgenerate

	always_comb
	begin
		rd_word = 16'h0000;
		for (int i = 0; i < SLCR_NUM_REGS; i++)
		begin
			if (hit[i])
				rd_word = regs_reg[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h00000000;
		else if (setup_phase && !pwrite)
			prdata_reg <= {16'h0000, rd_word};
	end

	// ==========================================================
	// slot fields
	logic [1:0] slot_a_emitter_choice;
	logic [1:0] slot_b_emitter_choice;
	logic [3:0] slot_a_detector_route;
	logic [3:0] slot_b_detector_route;
	logic [2:0] a_onehot;
	logic [2:0] b_onehot;
	logic a_detector;
	logic b_detector;

	assign slot_a_emitter_choice = regs_reg[SLCR_R_SLOT][SLCR_SLOT_A_CHOICE_LSB +: 2];
	assign slot_b_emitter_choice = regs_reg[SLCR_R_SLOT][SLCR_SLOT_B_CHOICE_LSB +: 2];
	assign slot_a_detector_route = regs_reg[SLCR_R_SLOT][SLCR_SLOT_A_ROUTE_LSB +: 4];
	assign slot_b_detector_route = regs_reg[SLCR_R_SLOT][SLCR_SLOT_B_ROUTE_LSB +: 4];

	slcr_slot_decode u_slot_a
	(
		.active(slot_a_active),
		.choice(slot_a_emitter_choice),
		.emit_onehot(a_onehot),
		.detector_connect(a_detector)
	);

	slcr_slot_decode u_slot_b
	(
		.active(slot_b_active),
		.choice(slot_b_emitter_choice),
		.emit_onehot(b_onehot),
		.detector_connect(b_detector)
	);

	// driver strobes
	// overlapping slots simply merge; slot timing keeps them apart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			emitter_driver_one_en <= 1'b0;
			emitter_driver_two_en <= 1'b0;
			emitter_driver_three_en <= 1'b0;
			detector_pulse_connect <= 1'b0;
		end
		else
		begin
			emitter_driver_one_en <= a_onehot[0] | b_onehot[0];
			emitter_driver_two_en <= a_onehot[1] | b_onehot[1];
			emitter_driver_three_en <= a_onehot[2] | b_onehot[2];
			detector_pulse_connect <= a_detector | b_detector;
		end
	end

	// detector routing
	// slot a wins if both are flagged at once
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			detector_input_route <= 4'h0;
		else if (slot_a_active)
			detector_input_route <= slot_a_detector_route;
		else if (slot_b_active)
			detector_input_route <= slot_b_detector_route;
		else
			detector_input_route <= 4'h0;
	end

	// ==========================================================
	// emitter drive settings
	slcr_drv_if drv3 ();
	slcr_drv_if drv1 ();

	assign drv3.ctrl_word = regs_reg[SLCR_R_LED3];
	assign drv3.fine = regs_reg[SLCR_R_FINE][SLCR_FINE3_LSB +: 5];
	assign drv1.ctrl_word = regs_reg[SLCR_R_LED1];
	assign drv1.fine = regs_reg[SLCR_R_FINE][SLCR_FINE1_LSB +: 5];

	slcr_emitter_unpack u_emit3
	(
		.drv(drv3.unpack)
	);

	slcr_emitter_unpack u_emit1
	(
		.drv(drv1.unpack)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			emitter3_strength_scale <= SLCR_RST_LED3_DRIVE_CONTROL[SLCR_SCALE_BIT];
			emitter3_low_power <= ~SLCR_RST_LED3_DRIVE_CONTROL[SLCR_SCALE_BIT];
			emitter3_edge_rate <= SLCR_RST_LED3_DRIVE_CONTROL[SLCR_EDGE_RATE_LSB +: 3];
			emitter3_coarse_current <= SLCR_RST_LED3_DRIVE_CONTROL[SLCR_COARSE_LSB +: 4];
			emitter3_fine_trim <= SLCR_RST_FINE_CURRENT[SLCR_FINE3_LSB +: 5];
		end
		else
		begin
			emitter3_strength_scale <= drv3.scale;
			emitter3_low_power <= drv3.low_power;
			emitter3_edge_rate <= drv3.edge_rate;
			emitter3_coarse_current <= drv3.coarse;
			emitter3_fine_trim <= drv3.fine;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			emitter1_strength_scale <= SLCR_RST_LED1_DRIVE_CONTROL[SLCR_SCALE_BIT];
			emitter1_low_power <= ~SLCR_RST_LED1_DRIVE_CONTROL[SLCR_SCALE_BIT];
			emitter1_edge_rate <= SLCR_RST_LED1_DRIVE_CONTROL[SLCR_EDGE_RATE_LSB +: 3];
			emitter1_coarse_current <= SLCR_RST_LED1_DRIVE_CONTROL[SLCR_COARSE_LSB +: 4];
			emitter1_fine_trim <= SLCR_RST_FINE_CURRENT[SLCR_FINE1_LSB +: 5];
		end
		else
		begin
			emitter1_strength_scale <= drv1.scale;
			emitter1_low_power <= drv1.low_power;
			emitter1_edge_rate <= drv1.edge_rate;
			emitter1_coarse_current <= drv1.coarse;
			emitter1_fine_trim <= drv1.fine;
		end
	end

	// ==========================================================
	// checks
	logic [3:0] strobes;

	// strobes side by side, detector connect on top
	assign strobes = {detector_pulse_connect, emitter_driver_three_en, emitter_driver_two_en,
		emitter_driver_one_en};

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence wr_lo_s(logic [7:0] idx);
		access_phase && pwrite && pstrb[0] && slcr_reg_hit(paddr, idx);
	endsequence

	sequence wr_hi_s(logic [7:0] idx);
		access_phase && pwrite && pstrb[1] && slcr_reg_hit(paddr, idx);
	endsequence

	// one slot alone, so the other cannot mask a wrong strobe
	sequence slot_a_only_s(logic [1:0] code);
		slot_a_active && !slot_b_active && slot_a_emitter_choice == code;
	endsequence

	sequence slot_b_only_s(logic [1:0] code);
		!slot_a_active && slot_b_active && slot_b_emitter_choice == code;
	endsequence

	// ==========================================================
	// register store and readback
	slot_a_choice_a: assert property (
		wr_lo_s(SLCR_IDX_SLOT_SOURCE_SELECT) |=> slot_a_emitter_choice == $past(pwdata[1:0]))
		else $error("slot a choice not stored");
	slot_b_choice_a: assert property (
		wr_lo_s(SLCR_IDX_SLOT_SOURCE_SELECT) |=> slot_b_emitter_choice == $past(pwdata[3:2]))
		else $error("slot b choice not stored");
	lane_hold_a: assert property (
		access_phase && pwrite && !pstrb[1] && hit[SLCR_R_LED3] |=>
		regs_reg[SLCR_R_LED3][15:8] == $past(regs_reg[SLCR_R_LED3][15:8]))
		else $error("unstrobed upper lane changed");
	stable_regs_a: assert property (
		!(access_phase && pwrite) |=> $stable(regs_reg[SLCR_R_SLOT]))
		else $error("slot register changed without a write");
	readback_a: assert property (
		setup_phase && !pwrite && hit[SLCR_R_SLOT] |=>
		prdata == {16'h0000, regs_reg[SLCR_R_SLOT]})
		else $error("slot register readback wrong");
	unmapped_zero_a: assert property (
		setup_phase && !pwrite && !hit_any |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");
	unmapped_err_a: assert property (
		access_phase && !hit_any |-> pslverr && pready)
		else $error("unmapped access not flagged");

	// ==========================================================
	// slot strobes and routing
	detector_mode_a: assert property (slot_a_only_s(2'h0) |=> strobes == 4'h8)
		else $error("code zero fired an emitter");
	detector_b_mode_a: assert property (slot_b_only_s(2'h0) |=> strobes == 4'h8)
		else $error("slot b code zero fired an emitter");
	emit_a_one_a: assert property (slot_a_only_s(2'h1) |=> strobes == 4'h1)
		else $error("slot a code one wrong");
	emit_a_two_a: assert property (slot_a_only_s(2'h2) |=> strobes == 4'h2)
		else $error("slot a code two wrong");
	emit_a_three_a: assert property (slot_a_only_s(2'h3) |=> strobes == 4'h4)
		else $error("slot a code three wrong");
	emit_b_one_a: assert property (slot_b_only_s(2'h1) |=> strobes == 4'h1)
		else $error("slot b code one wrong");
	emit_b_two_a: assert property (slot_b_only_s(2'h2) |=> strobes == 4'h2)
		else $error("slot b code two wrong");
	emit_b_three_a: assert property (slot_b_only_s(2'h3) |=> strobes == 4'h4)
		else $error("slot b code three wrong");
	route_a_a: assert property (
		slot_a_active |=> detector_input_route == $past(slot_a_detector_route))
		else $error("slot a route wrong");
	route_b_a: assert property (
		!slot_a_active && slot_b_active |=> detector_input_route == $past(slot_b_detector_route))
		else $error("slot b route wrong");
	route_idle_a: assert property (
		!slot_a_active && !slot_b_active |=> detector_input_route == 4'h0)
		else $error("route not cleared between slots");

	// ==========================================================
	// emitter drive settings, two edges after the write
	scale3_low_a: assert property (
		wr_hi_s(SLCR_IDX_LED3_DRIVE_CONTROL) ##1 1'b1 |=>
		emitter3_low_power == !$past(pwdata[13], 2) &&
		emitter3_strength_scale != emitter3_low_power)
		else $error("driver three scale wrong");
	edge_rate3_a: assert property (
		wr_lo_s(SLCR_IDX_LED3_DRIVE_CONTROL) ##2 1'b1 |->
		emitter3_edge_rate == $past(pwdata[6:4], 2))
		else $error("driver three edge rate wrong");
	coarse3_a: assert property (
		wr_lo_s(SLCR_IDX_LED3_DRIVE_CONTROL) ##2 1'b1 |->
		emitter3_coarse_current == $past(pwdata[3:0], 2))
		else $error("driver three coarse wrong");
	fine3_a: assert property (
		wr_hi_s(SLCR_IDX_FINE_CURRENT) ##2 1'b1 |->
		emitter3_fine_trim == $past(pwdata[15:11], 2))
		else $error("driver three fine trim wrong");
	scale1_low_a: assert property (
		wr_hi_s(SLCR_IDX_LED1_DRIVE_CONTROL) ##2 1'b1 |->
		emitter1_low_power == !$past(pwdata[13], 2))
		else $error("driver one scale wrong");
endmodule
`default_nettype wire

// >>> rtl/slcr_pkg.sv
// constants and helpers shared by the slot and emitter configuration bank
package slcr_pkg;

	// ==========================================================
	// register map (indices; the byte address is four times the index)
	localparam int SLCR_ADDR_W = 12;
	localparam int SLCR_NUM_REGS = 4;
	localparam logic [7:0] SLCR_IDX_SLOT_SOURCE_SELECT = 8'h14;
	localparam logic [7:0] SLCR_IDX_LED3_DRIVE_CONTROL = 8'h22;
	localparam logic [7:0] SLCR_IDX_LED1_DRIVE_CONTROL = 8'h23;
	localparam logic [7:0] SLCR_IDX_FINE_CURRENT = 8'h25;

	// array slots of the register file
	localparam int SLCR_R_SLOT = 0;
	localparam int SLCR_R_LED3 = 1;
	localparam int SLCR_R_LED1 = 2;
	localparam int SLCR_R_FINE = 3;

	// ==========================================================
	// reset values
	localparam logic [15:0] SLCR_RST_SLOT_SOURCE_SELECT = 16'h0541;
	localparam logic [15:0] SLCR_RST_LED3_DRIVE_CONTROL = 16'h3000;
	localparam logic [15:0] SLCR_RST_LED1_DRIVE_CONTROL = 16'h3000;
	localparam logic [15:0] SLCR_RST_FINE_CURRENT = 16'h0000;

	localparam logic [7:0] SLCR_IDX_LIST [SLCR_NUM_REGS] = '{
		SLCR_IDX_SLOT_SOURCE_SELECT, SLCR_IDX_LED3_DRIVE_CONTROL,
		SLCR_IDX_LED1_DRIVE_CONTROL, SLCR_IDX_FINE_CURRENT};
	localparam logic [15:0] SLCR_RST_LIST [SLCR_NUM_REGS] = '{
		SLCR_RST_SLOT_SOURCE_SELECT, SLCR_RST_LED3_DRIVE_CONTROL,
		SLCR_RST_LED1_DRIVE_CONTROL, SLCR_RST_FINE_CURRENT};

	// ==========================================================
	// field positions
	localparam int SLCR_SLOT_A_CHOICE_LSB = 0;
	localparam int SLCR_SLOT_B_CHOICE_LSB = 2;
	localparam int SLCR_SLOT_A_ROUTE_LSB = 4;
	localparam int SLCR_SLOT_B_ROUTE_LSB = 8;
	localparam int SLCR_SCALE_BIT = 13;
	localparam int SLCR_EDGE_RATE_LSB = 4;
	localparam int SLCR_COARSE_LSB = 0;
	localparam int SLCR_FINE3_LSB = 11;
	localparam int SLCR_FINE1_LSB = 0;

	// ==========================================================
	// emitter choice codes
	typedef enum logic [1:0]
	{
		SLCR_CHOICE_DETECTOR = 2'h0,
		SLCR_CHOICE_DRIVER_ONE = 2'h1,
		SLCR_CHOICE_DRIVER_TWO = 2'h2,
		SLCR_CHOICE_DRIVER_THREE = 2'h3
	} slcr_choice_t;

	function automatic logic [SLCR_ADDR_W-1:0] slcr_byte_addr(input logic [7:0] idx);
		slcr_byte_addr = {2'h0, idx, 2'h0};
	endfunction

endpackage

// >>> rtl/slcr_drv_if.sv
// carrier between the register bank and an emitter control unpacker
`timescale 1ns/1ps
`default_nettype none
interface slcr_drv_if;
	logic [15:0] ctrl_word;
	logic [4:0] fine;
	logic scale;
	logic low_power;
	logic [2:0] edge_rate;
	logic [3:0] coarse;

	modport bank
	(
		output ctrl_word,
		output fine,
		input scale,
		input low_power,
		input edge_rate,
		input coarse
	);

	modport unpack
	(
		input ctrl_word,
		input fine,
		output scale,
		output low_power,
		output edge_rate,
		output coarse
	);
endinterface
`default_nettype wire

// >>> rtl/slcr_emitter_unpack.sv
// splits one emitter control word into its drive settings
`timescale 1ns/1ps
`default_nettype none
module slcr_emitter_unpack
	import slcr_pkg::*;
(
	slcr_drv_if.unpack drv
);
	assign drv.scale = drv.ctrl_word[SLCR_SCALE_BIT];
	// scale low means ten percent drive and low power
	assign drv.low_power = ~drv.ctrl_word[SLCR_SCALE_BIT];
	assign drv.edge_rate = drv.ctrl_word[SLCR_EDGE_RATE_LSB +: 3];
	assign drv.coarse = drv.ctrl_word[SLCR_COARSE_LSB +: 4];
endmodule
`default_nettype wire

// >>> rtl/slcr_slot_decode.sv
// turns a slot emitter choice into driver strobes or detector connect
`timescale 1ns/1ps
`default_nettype none
module slcr_slot_decode
	import slcr_pkg::*;
(
	input wire logic active,
	input wire logic [1:0] choice,
	output logic [2:0] emit_onehot,
	output logic detector_connect
);
	always_comb
	begin
		emit_onehot = 3'h0;
		detector_connect = 1'b0;
		if (active)
		begin
			case (slcr_choice_t'(choice))
				SLCR_CHOICE_DRIVER_ONE: emit_onehot = 3'h1;
				SLCR_CHOICE_DRIVER_TWO: emit_onehot = 3'h2;
				SLCR_CHOICE_DRIVER_THREE: emit_onehot = 3'h4;
				default: detector_connect = 1'b1;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the slot and emitter configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
	$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module tb_top
	import slcr_pkg::*;
;
	// ==========================================================
	// signals
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [SLCR_ADDR_W-1:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic slot_a_active;
	logic slot_b_active;
	logic drv1_en, drv2_en, drv3_en, det_conn;
	logic [3:0] route;
	logic e3_scale, e3_low, e1_scale, e1_low;
	logic [2:0] e3_rate, e1_rate;
	logic [3:0] e3_coarse, e1_coarse;
	logic [4:0] e3_fine, e1_fine;
	logic [31:0] rdata;
	logic err;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	logic [15:0] drv_vals [3] = '{16'h107F, 16'h3035, 16'h3000};

	slcr_bank uut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .slot_a_active(slot_a_active), .slot_b_active(slot_b_active),
		.emitter_driver_one_en(drv1_en), .emitter_driver_two_en(drv2_en),
		.emitter_driver_three_en(drv3_en), .detector_pulse_connect(det_conn),
		.detector_input_route(route), .emitter3_strength_scale(e3_scale),
		.emitter3_low_power(e3_low), .emitter3_edge_rate(e3_rate),
		.emitter3_coarse_current(e3_coarse), .emitter3_fine_trim(e3_fine),
		.emitter1_strength_scale(e1_scale), .emitter1_low_power(e1_low),
		.emitter1_edge_rate(e1_rate), .emitter1_coarse_current(e1_coarse),
		.emitter1_fine_trim(e1_fine)
	);

	// ==========================================================
	// clock, timeout, verdict
	initial
	begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	// whole run is under two hundred cycles; generous margin
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// bus and check helpers
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rdata = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
		apb(1'h0, idx, 16'h0000, 4'h0);
		`CHK(rdata, {16'h0000, exp})
		`CHK(err, 1'h0)
	endtask

	// outputs are registered: let the update edge land first
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic chk_slot(input int code, input logic [3:0] exp_route);
		`CHK({drv1_en, drv2_en, drv3_en}, {code == 1, code == 2, code == 3})
		`CHK(det_conn, code == 0)
		`CHK(route, exp_route)
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		rd_chk(SLCR_IDX_SLOT_SOURCE_SELECT, 16'h0541);
		rd_chk(SLCR_IDX_LED3_DRIVE_CONTROL, 16'h3000);
		rd_chk(SLCR_IDX_LED1_DRIVE_CONTROL, 16'h3000);
		rd_chk(SLCR_IDX_FINE_CURRENT, 16'h0000);
		`CHK({e3_scale, e3_low, e3_rate, e3_coarse}, 9'h100)
		`CHK({e1_scale, e1_low, e1_rate, e1_coarse}, 9'h100)
		`CHK({e3_fine, e1_fine}, 10'h000)
	endtask

	task automatic t_slots();
		for (int c = 0; c < 4; c++)
		begin
			apb(1'h1, SLCR_IDX_SLOT_SOURCE_SELECT, {8'h03, 4'hA, 2'(3 - c), 2'(c)}, 4'h3);
			rd_chk(SLCR_IDX_SLOT_SOURCE_SELECT, {8'h03, 4'hA, 2'(3 - c), 2'(c)});
			@(posedge pclk);
			slot_a_active <= 1'h1;
			settle(1);
			chk_slot(c, 4'hA);
			@(posedge pclk);
			slot_a_active <= 1'h0;
			slot_b_active <= 1'h1;
			settle(1);
			chk_slot(3 - c, 4'h3);
			@(posedge pclk);
			slot_b_active <= 1'h0;
			settle(1);
			`CHK({drv1_en, drv2_en, drv3_en, det_conn, route}, 8'h00)
		end
		// both slots at once: strobes merge and slot a owns the route
		@(posedge pclk);
		slot_a_active <= 1'h1;
		slot_b_active <= 1'h1;
		settle(1);
		`CHK({drv1_en, drv2_en, drv3_en, det_conn, route}, {4'h3, 4'hA})
		@(posedge pclk);
		slot_a_active <= 1'h0;
		slot_b_active <= 1'h0;
	endtask

	task automatic t_drivers();
		for (int i = 0; i < 3; i++)
		begin
			apb(1'h1, SLCR_IDX_LED3_DRIVE_CONTROL, drv_vals[i], 4'h3);
			apb(1'h1, SLCR_IDX_LED1_DRIVE_CONTROL, drv_vals[2 - i], 4'h3);
			settle(1);
			`CHK({e3_scale, e3_low}, {drv_vals[i][13], ~drv_vals[i][13]})
			`CHK(e3_rate, drv_vals[i][6:4])
			`CHK(e3_coarse, drv_vals[i][3:0])
			`CHK({e1_scale, e1_low}, {drv_vals[2 - i][13], ~drv_vals[2 - i][13]})
			`CHK({e1_rate, e1_coarse}, {drv_vals[2 - i][6:4], drv_vals[2 - i][3:0]})
			rd_chk(SLCR_IDX_LED3_DRIVE_CONTROL, drv_vals[i]);
		end
		// low lane only: scale bit in the upper lane must survive
		apb(1'h1, SLCR_IDX_LED3_DRIVE_CONTROL, 16'h007F, 4'h1);
		rd_chk(SLCR_IDX_LED3_DRIVE_CONTROL, 16'h307F);
	endtask

	task automatic t_fine();
		apb(1'h1, SLCR_IDX_FINE_CURRENT, 16'hF803, 4'h3);
		settle(1);
		`CHK(e3_fine, 5'h1F)
		`CHK(e1_fine, 5'h03)
		apb(1'h1, SLCR_IDX_FINE_CURRENT, 16'h07FC, 4'h3);
		settle(1);
		`CHK(e3_fine, 5'h00)
		rd_chk(SLCR_IDX_FINE_CURRENT, 16'h07FC);
	endtask

	task automatic t_unmapped();
		apb(1'h1, 8'h10, 16'hFFFF, 4'h3);
		`CHK(err, 1'h1)
		apb(1'h0, 8'h10, 16'h0000, 4'h0);
		`CHK({err, rdata}, {1'h1, 32'h0000_0000})
		rd_chk(SLCR_IDX_SLOT_SOURCE_SELECT, 16'h03A3);
	endtask

	// reset in mid-run with a slot still flagged: everything falls back
	task automatic t_rerun();
		@(posedge pclk);
		slot_a_active <= 1'h1;
		presetn <= 1'h0;
		settle(2);
		`CHK({drv1_en, drv2_en, drv3_en, det_conn, route}, 8'h00)
		@(posedge pclk);
		slot_a_active <= 1'h0;
		presetn <= 1'h1;
		t_reset();
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = '0;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		slot_a_active = 1'h0;
		slot_b_active = 1'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_slots();
		t_drivers();
		t_fine();
		t_unmapped();
		t_rerun();
		wrap_up();
	end
endmodule
`default_nettype wire
